/* mxc_pkg.sv */
package mxc_pkg;
  // ==========================================================
  // register offsets
  localparam logic [11:0] MXC_MSG_CTRL_OFS   = 12'h068;
  localparam logic [11:0] MXC_TABLE_LOC_OFS  = 12'h06C;
  localparam logic [11:0] MXC_PEND_LOC_OFS   = 12'h070;
  localparam logic [11:0] MXC_INTX_SEL_OFS   = 12'h074;
  // ==========================================================
  // field positions
  localparam int MXC_TSIZE_LSB  = 16;
  localparam int MXC_TSIZE_MSB  = 26;
  localparam int MXC_ENABLE_BIT = 31;
  localparam int MXC_BIR_MSB    = 2;
  // ==========================================================
  // build defaults
  localparam logic [10:0] MXC_TSIZE_RST = 11'h000;
  localparam logic [31:0] MXC_TOFS_RST  = 32'h0000_0000;
  localparam logic [31:0] MXC_POFS_RST  = 32'h0000_0000;
  localparam logic [2:0]  MXC_BIR_RST   = 3'h0;
  localparam logic [2:0]  MXC_BIR_MAX   = 3'h5;
  localparam logic [31:0] MXC_ZERO_WORD = 32'h0000_0000;
  // ==========================================================
  // legacy interrupt pin choice
  typedef enum logic [2:0]
  {
    MXC_INTX_NONE = 3'h0,
    MXC_INTX_A    = 3'h1,
    MXC_INTX_B    = 3'h2,
    MXC_INTX_C    = 3'h3,
    MXC_INTX_D    = 3'h4
  } mxc_intx_type;
endpackage

/* mxc_msix_caps.sv */
`timescale 1ns/1ps
// What this block does
// - msix fields and behaviour exist only when the msix build option is on
// - table size, entries minus one, read-only in bits 26:16 at 0x068
// - read-only 32-bit table offset; low 3 bits carry the bar indicator
// - read-only 3-bit table bar indicator, legal values 0 to 5
// - read-only 32-bit pending array offset; low 3 bits hold its indicator
// - read-only 3-bit pending array bar indicator, legal values 0 to 5
// - one legacy pin a to d, or none, chosen at build time
module mxc_msix_caps
  import mxc_pkg::*;
#(
  parameter bit           MSIX_ON    = 1'b1,
  parameter logic [10:0]  TABLE_SIZE = MXC_TSIZE_RST,
  parameter logic [31:0]  TABLE_OFS  = MXC_TOFS_RST,
  parameter logic [2:0]   TABLE_BIR  = MXC_BIR_RST,
  parameter logic [31:0]  PEND_OFS   = MXC_POFS_RST,
  parameter logic [2:0]   PEND_BIR   = MXC_BIR_RST,
  parameter mxc_intx_type INTX_PIN   = MXC_INTX_A
)
(
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic [11:0] addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  input  wire logic        app_intx,
  output logic      [31:0] rdata,
  output logic      [3:0]  intx_out
);

  // ==========================================================
  // constant register images
  function automatic logic [31:0] place_bir(input logic [31:0] ofs, input logic [2:0] bir);
    place_bir = {ofs[31:MXC_BIR_MSB+1], bir};
  endfunction

  logic [31:0] ctrl_word;
  logic [31:0] tloc_word;
  logic [31:0] ploc_word;

  always_comb
  begin
    ctrl_word = MXC_ZERO_WORD;
    tloc_word = MXC_ZERO_WORD;
    ploc_word = MXC_ZERO_WORD;
    if (MSIX_ON)
    begin
      ctrl_word[MXC_TSIZE_MSB:MXC_TSIZE_LSB] = TABLE_SIZE;
      tloc_word = place_bir(TABLE_OFS, TABLE_BIR);
      ploc_word = place_bir(PEND_OFS, PEND_BIR);
    end
  end

  // ==========================================================
  // read port
  logic [31:0] rdata_d;
  logic [31:0] rdata_q;

  always_comb
  begin
    rdata_d = MXC_ZERO_WORD;
    if (rd)
    begin
      unique case (addr)
        MXC_MSG_CTRL_OFS:  rdata_d = ctrl_word;
        MXC_TABLE_LOC_OFS: rdata_d = tloc_word;
        MXC_PEND_LOC_OFS:  rdata_d = ploc_word;
        MXC_INTX_SEL_OFS:  rdata_d = {29'h0000_0000, INTX_PIN};
        default:           rdata_d = MXC_ZERO_WORD;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      rdata_q <= MXC_ZERO_WORD;
    else
      rdata_q <= rdata_d;
  end

  assign rdata = rdata_q;

  // ==========================================================
  // legacy interrupt routing
  logic [3:0] intx_d;
  logic [3:0] intx_q;

  always_comb
  begin
    intx_d = 4'h0;
    unique case (INTX_PIN)
      MXC_INTX_A: intx_d[0] = app_intx;
      MXC_INTX_B: intx_d[1] = app_intx;
      MXC_INTX_C: intx_d[2] = app_intx;
      MXC_INTX_D: intx_d[3] = app_intx;
      default:    intx_d = 4'h0;
    endcase
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      intx_q <= 4'h0;
    else
      intx_q <= intx_d;
  end

  assign intx_out = intx_q;

  // ==========================================================
  // checks
  size_read_a: assert property (@(posedge clk) disable iff (!resetn)
    rd && addr == MXC_MSG_CTRL_OFS |=> rdata[26:16] == (MSIX_ON ? TABLE_SIZE : 11'h000))
    else $error("table size read wrong");
  tloc_read_a: assert property (@(posedge clk) disable iff (!resetn)
    rd && addr == MXC_TABLE_LOC_OFS |=> rdata[31:3] == (MSIX_ON ? TABLE_OFS[31:3] : 29'h0))
    else $error("table offset read wrong");
  tbir_read_a: assert property (@(posedge clk) disable iff (!resetn)
    rd && addr == MXC_TABLE_LOC_OFS && MSIX_ON |=> rdata[2:0] == TABLE_BIR && rdata[2:0] <= MXC_BIR_MAX)
    else $error("table bir read wrong");
  ploc_read_a: assert property (@(posedge clk) disable iff (!resetn)
    rd && addr == MXC_PEND_LOC_OFS |=> rdata[31:3] == (MSIX_ON ? PEND_OFS[31:3] : 29'h0))
    else $error("pending offset read wrong");
  pbir_read_a: assert property (@(posedge clk) disable iff (!resetn)
    rd && addr == MXC_PEND_LOC_OFS && MSIX_ON |=> rdata[2:0] == PEND_BIR)
    else $error("pending bir read wrong");
  msix_off_a: assert property (@(posedge clk) disable iff (!resetn)
    !MSIX_ON && rd && addr != MXC_INTX_SEL_OFS |=> rdata == MXC_ZERO_WORD)
    else $error("msix field visible while off");
  intx_route_a: assert property (@(posedge clk) disable iff (!resetn)
    app_intx && INTX_PIN != MXC_INTX_NONE |=> $countones(intx_out) == 1)
    else $error("legacy pin not routed");
  write_ignored_a: assert property (@(posedge clk) disable iff (!resetn)
    wr ##1 rd && addr == MXC_MSG_CTRL_OFS |=> rdata == (MSIX_ON ? {5'h00, TABLE_SIZE, 16'h0000} : MXC_ZERO_WORD))
    else $error("write changed a field");
  intx_quiet_a: assert property (@(posedge clk) disable iff (!resetn)
    !app_intx |=> intx_out == 4'h0)
    else $error("legacy pin active without request");
  idle_zero_a: assert property (@(posedge clk) disable iff (!resetn)
    !rd |=> rdata == MXC_ZERO_WORD)
    else $error("read data outside read slot");

endmodule // mxc_msix_caps

/* mxc_host.sv */
`timescale 1ns/1ps
// ==========================================================
// host configuration reader and writer
module mxc_host
(
  input  wire logic        clk,
  output logic      [11:0] addr,
  output logic      [31:0] wdata,
  output logic             wr,
  output logic             rd,
  input  wire logic [31:0] rdata
);
  initial
  begin
    addr  = 12'h000;
    wdata = 32'h0000_0000;
    wr    = 1'b0;
    rd    = 1'b0;
  end
  task automatic cfg_rd(input logic [11:0] a, output logic [31:0] v);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd   <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic cfg_wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr    <= 1'b0;
  endtask
endmodule // mxc_host

/* mxc_msix_caps_tb.sv */
`timescale 1ns/1ps
// ==========================================================
// testbench
module mxc_msix_caps_tb import mxc_pkg::*;;
  logic        clk = 1'b0;
  logic        resetn;
  logic        app_intx;
  logic [11:0] addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic [31:0] rdata;
  logic [3:0]  intx_out;
  logic [31:0] v;
  int          n_mismatch = 0;
  int          cmp_count = 0;
  always #20 clk = ~clk;
  mxc_msix_caps #(.TABLE_SIZE(11'h7FF), .TABLE_OFS(32'h0001_2340), .TABLE_BIR(3'h5),
    .PEND_BIR(3'h2), .INTX_PIN(MXC_INTX_C)) mxc_msix_caps_i (.clk(clk),
    .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .app_intx(app_intx), .rdata(rdata),
    .intx_out(intx_out));
  mxc_host mxc_host_i (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
    mxc_host_i.cfg_rd(a, v);
    check(v, e);
  endtask
  task automatic conclude;
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    #100000;
    n_mismatch++;
    conclude();
  end
  initial
  begin
    resetn   = 1'b0;
    app_intx = 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    rd_chk(MXC_MSG_CTRL_OFS, 32'h07FF_0000);
    @(posedge clk) #1 check(rdata, 32'h0000_0000);
    rd_chk(MXC_TABLE_LOC_OFS, 32'h0001_2345);
    rd_chk(MXC_PEND_LOC_OFS, 32'h0000_0002);
    rd_chk(MXC_INTX_SEL_OFS, 32'h0000_0003);
    rd_chk(12'h000, 32'h0000_0000);
    mxc_host_i.cfg_wr(MXC_MSG_CTRL_OFS, 32'hFFFF_FFFF);
    mxc_host_i.cfg_wr(MXC_TABLE_LOC_OFS, 32'hFFFF_FFFF);
    rd_chk(MXC_MSG_CTRL_OFS, 32'h07FF_0000);
    rd_chk(MXC_TABLE_LOC_OFS, 32'h0001_2345);
    rd_chk(MXC_PEND_LOC_OFS, 32'h0000_0002);
    @(posedge clk) app_intx <= 1'b1;
    @(posedge clk) #1 check({28'h0, intx_out}, 32'h0000_0004);
    @(posedge clk) app_intx <= 1'b0;
    @(posedge clk) #1 check({28'h0, intx_out}, 32'h0000_0000);
    conclude();
  end
endmodule // mxc_msix_caps_tb
